// file: dtm_pkg.sv
// Package for the loop timing-mode control block
package dtm_pkg;

    // ========================================
    // Register byte offsets
    localparam logic [7:0] DTM_OFF_LOOP_CTRL   = 8'h00;
    localparam logic [7:0] DTM_OFF_REF_CHANGE  = 8'h04;
    localparam logic [7:0] DTM_OFF_DELTA_FREQ  = 8'h08;
    localparam logic [7:0] DTM_OFF_CENTRE_FREQ = 8'h0c;
    localparam logic [7:0] DTM_OFF_LOCK_THR    = 8'h10;
    localparam logic [7:0] DTM_OFF_STATUS      = 8'h14;
    localparam logic [7:0] DTM_OFF_FREQ_NOW    = 8'h18;

    // ========================================
    // Loop control fields
    localparam int DTM_LC_IRM_BIT = 0;
    localparam int DTM_LC_SWE_BIT = 3;
    localparam int DTM_LC_SWF_BIT = 4;

    // ========================================
    // Reference change control fields
    localparam int DTM_RC_MODE_LSB = 0;
    localparam int DTM_RC_REF_LSB  = 4;
    localparam int DTM_RC_PMS_LSB  = 8;

    // ========================================
    // Reset values
    localparam logic [31:0] DTM_RST_LOOP_CTRL   = 32'h0000_0000;
    localparam logic [31:0] DTM_RST_REF_CHANGE  = 32'h0000_0003;
    localparam logic [31:0] DTM_RST_CENTRE_FREQ = 32'h0800_0000;
    localparam logic [15:0] DTM_RST_LOCK_THR    = 16'h0040;

    // ========================================
    // Preference selector codes
    localparam logic [2:0] DTM_PMS_ROUND_ROBIN = 3'h0;
    localparam logic [2:0] DTM_PMS_PREFERRED   = 3'h1;

    // ========================================
    // Timing
    localparam int DTM_CLK_MHZ      = 200;
    localparam int DTM_LOCK_INT_US  = 4000;
    localparam int DTM_LOCK_CYC     = DTM_LOCK_INT_US * DTM_CLK_MHZ;
    localparam int DTM_HOLD_SAVE_CYC = DTM_LOCK_CYC;
    localparam int DTM_STEP_SHIFT   = 4;

    // Requested timing mode
    typedef enum logic [1:0] {
        DTM_REQ_NORMAL   = 2'b00,
        DTM_REQ_HOLDOVER = 2'b01,
        DTM_REQ_AUTO     = 2'b10,
        DTM_REQ_FREERUN  = 2'b11
    } dtm_req_t;

    // Operating state
    typedef enum logic [2:0] {
        DTM_ST_RESET    = 3'b000,
        DTM_ST_FREERUN  = 3'b001,
        DTM_ST_NORMAL   = 3'b010,
        DTM_ST_HOLDOVER = 3'b011
    } dtm_state_t;

endpackage

// file: dtm_timing_ctrl.sv
// Loop timing-mode and reference-selection control with APB registers
`timescale 1ns/10ps

module dtm_timing_ctrl #(
    parameter int unsigned LOCK_CYC  = dtm_pkg::DTM_LOCK_CYC,
    parameter int unsigned SAVE_CYC  = dtm_pkg::DTM_HOLD_SAVE_CYC,
    parameter int unsigned NCO_W     = 32
) (
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              arst_n_in,
    // APB slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [7:0]        paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // Reference side
    input  wire logic [3:0]        timing_ref_inputs_in,
    input  wire logic [3:0]        ref_valid_in,
    input  wire logic [15:0]       phase_err_in,
    // Loop outputs
    output logic [NCO_W-1:0]       nco_freq_out,
    output logic [1:0]             active_ref_out,
    output logic                   loop_run_out,
    output logic                   track_ref_out,
    output logic                   locked_out,
    output logic [5:0]             out_clk_en_out,
    output logic [4:0]             frame_pulse_en_out
);

    // ========================================
    // State
    typedef struct packed {
        logic [3:0]       ref_s1;
        logic [3:0]       ref_s2;
        logic [3:0]       val_s1;
        logic [3:0]       val_s2;
        logic [31:0]      loop_control_reg;
        logic [31:0]      reference_change_control;
        logic [31:0]      soft_delta_freq_reg;
        logic [31:0]      centre_q;
        logic [15:0]      lock_thr;
        dtm_pkg::dtm_state_t st;
        logic [1:0]       act_ref;
        logic [NCO_W-1:0] freq;
        logic [NCO_W-1:0] save_new;
        logic [NCO_W-1:0] save_old;
        logic [31:0]      save_cnt;
        logic [31:0]      lock_cnt;
        logic             lock_ok;
        logic             locked;
        logic [31:0]      rdata;
        logic             ready;
        logic             slverr;
        logic [NCO_W-1:0] freq_o;
        logic [1:0]       ref_o;
        logic             run_o;
        logic             trk_o;
        logic [5:0]       ck_en;
        logic [4:0]       fp_en;
    } dtm_regs_t;

    dtm_regs_t r_q;
    dtm_regs_t r_d;

    logic             setup_c;
    logic [2:0]       pms_c;
    logic [1:0]       mode_c;
    logic [1:0]       fref_c;
    logic             irm_c;
    logic             swe_c;
    logic             swf_c;
    logic [1:0]       nxt_c;
    logic             nxt_ok_c;
    logic [NCO_W-1:0] target_c;
    logic [NCO_W-1:0] diff_c;
    logic [3:0]       rv_c;

    // ========================================
    // Next-state logic
    always_comb begin
        r_d = r_q;
        // Pin synchronisers
        r_d.ref_s1 = timing_ref_inputs_in;
        r_d.ref_s2 = r_q.ref_s1;
        r_d.val_s1 = ref_valid_in;
        r_d.val_s2 = r_q.val_s1;
        rv_c = r_q.val_s2;

        irm_c  = r_q.loop_control_reg[dtm_pkg::DTM_LC_IRM_BIT];
        swe_c  = r_q.loop_control_reg[dtm_pkg::DTM_LC_SWE_BIT];
        swf_c  = r_q.loop_control_reg[dtm_pkg::DTM_LC_SWF_BIT];
        mode_c = r_q.reference_change_control[dtm_pkg::DTM_RC_MODE_LSB +: 2];
        fref_c = r_q.reference_change_control[dtm_pkg::DTM_RC_REF_LSB +: 2];
        pms_c  = r_q.reference_change_control[dtm_pkg::DTM_RC_PMS_LSB +: 3];

        // APB access, single wait-free cycle
        setup_c = psel_in && !penable_in;
        r_d.ready = setup_c;
        r_d.slverr = 1'b0;
        r_d.rdata = 32'h0000_0000;
        if (setup_c) begin
            if (pwrite_in) begin
                case (paddr_in)
                    dtm_pkg::DTM_OFF_LOOP_CTRL:
                        r_d.loop_control_reg = pwdata_in & 32'h0000_0019;
                    dtm_pkg::DTM_OFF_REF_CHANGE:
                        r_d.reference_change_control = pwdata_in
                            & 32'h0000_0733;
                    dtm_pkg::DTM_OFF_DELTA_FREQ:
                        r_d.soft_delta_freq_reg = pwdata_in;
                    dtm_pkg::DTM_OFF_CENTRE_FREQ:
                        r_d.centre_q = pwdata_in;
                    dtm_pkg::DTM_OFF_LOCK_THR:
                        r_d.lock_thr = pwdata_in[15:0];
                    dtm_pkg::DTM_OFF_STATUS,
                    dtm_pkg::DTM_OFF_FREQ_NOW: begin
                    end
                    default: r_d.slverr = 1'b1;
                endcase
            end else begin
                case (paddr_in)
                    dtm_pkg::DTM_OFF_LOOP_CTRL:
                        r_d.rdata = r_q.loop_control_reg;
                    dtm_pkg::DTM_OFF_REF_CHANGE:
                        r_d.rdata = r_q.reference_change_control;
                    dtm_pkg::DTM_OFF_DELTA_FREQ:
                        r_d.rdata = r_q.soft_delta_freq_reg;
                    dtm_pkg::DTM_OFF_CENTRE_FREQ:
                        r_d.rdata = r_q.centre_q;
                    dtm_pkg::DTM_OFF_LOCK_THR:
                        r_d.rdata = {16'h0000, r_q.lock_thr};
                    dtm_pkg::DTM_OFF_STATUS:
                        r_d.rdata = {20'h00000, rv_c, 1'b0, r_q.locked,
                                     r_q.act_ref, 1'b0, r_q.st};
                    dtm_pkg::DTM_OFF_FREQ_NOW:
                        r_d.rdata = 32'(r_q.freq);
                    default: r_d.slverr = 1'b1;
                endcase
            end
        end

        // Next candidate in search order
        // round robin order; preferred mode tries fref_c, then fref_c + 1 only
        nxt_c = r_q.act_ref + 2'h1;
        nxt_ok_c = 1'b0;
        if (pms_c == dtm_pkg::DTM_PMS_PREFERRED) begin
            if (rv_c[fref_c]) begin
                nxt_c = fref_c;
                nxt_ok_c = 1'b1;
            end else if (rv_c[2'(fref_c + 2'h1)]) begin
                nxt_c = 2'(fref_c + 2'h1);
                nxt_ok_c = 1'b1;
            end
        end else begin
            for (int i = 1; i <= 4; i++) begin
                if (!nxt_ok_c && rv_c[2'(r_q.act_ref + 2'(i))]) begin
                    nxt_c = 2'(r_q.act_ref + 2'(i));
                    nxt_ok_c = 1'b1;
                end
            end
        end

        // Mode state machine
        // mode selection
        case (r_q.st)
            dtm_pkg::DTM_ST_RESET,
            dtm_pkg::DTM_ST_FREERUN,
            dtm_pkg::DTM_ST_NORMAL,
            dtm_pkg::DTM_ST_HOLDOVER: begin
                case (dtm_pkg::dtm_req_t'(mode_c))
                    dtm_pkg::DTM_REQ_NORMAL: begin
                        r_d.st = dtm_pkg::DTM_ST_NORMAL;
                        r_d.act_ref = fref_c;
                    end
                    dtm_pkg::DTM_REQ_HOLDOVER:
                        r_d.st = dtm_pkg::DTM_ST_HOLDOVER;
                    dtm_pkg::DTM_REQ_AUTO: begin
                        if (r_q.st == dtm_pkg::DTM_ST_NORMAL
                            && rv_c[r_q.act_ref]
                            && (pms_c != dtm_pkg::DTM_PMS_PREFERRED
                                || r_q.act_ref == fref_c
                                || !rv_c[fref_c])) begin
                            r_d.st = dtm_pkg::DTM_ST_NORMAL;
                        end else if (nxt_ok_c) begin
                            r_d.st = dtm_pkg::DTM_ST_NORMAL;
                            r_d.act_ref = nxt_c;
                        end else begin
                            r_d.st = dtm_pkg::DTM_ST_HOLDOVER;
                        end
                    end
                    default: r_d.st = dtm_pkg::DTM_ST_FREERUN;
                endcase
            end
            default: r_d.st = dtm_pkg::DTM_ST_FREERUN;
        endcase
        if (irm_c) begin
            r_d.st = dtm_pkg::DTM_ST_RESET;
        end

        // Frequency word
        target_c = NCO_W'(r_q.centre_q);
        diff_c = '0;
        case (r_q.st)
            dtm_pkg::DTM_ST_NORMAL: begin
                r_d.freq = r_q.freq + NCO_W'({{16{phase_err_in[15]}},
                    phase_err_in} >>> dtm_pkg::DTM_STEP_SHIFT);
                if (r_q.save_cnt >= SAVE_CYC - 1) begin
                    r_d.save_cnt = '0;
                    r_d.save_old = r_q.save_new;
                    r_d.save_new = r_q.freq;
                end else begin
                    r_d.save_cnt = r_q.save_cnt + 32'h1;
                end
            end
            dtm_pkg::DTM_ST_HOLDOVER: begin
                r_d.freq = r_q.save_old;
            end
            dtm_pkg::DTM_ST_FREERUN: begin
                if (swe_c) begin
                    target_c = NCO_W'(r_q.centre_q
                        + r_q.soft_delta_freq_reg);
                end
                if (swe_c && swf_c) begin
                    r_d.freq = target_c;
                end else if (swe_c) begin
                    diff_c = target_c - r_q.freq;
                    r_d.freq = r_q.freq + NCO_W'($signed(diff_c)
                        >>> dtm_pkg::DTM_STEP_SHIFT);
                    if (diff_c != '0 && r_d.freq == r_q.freq) begin
                        r_d.freq = target_c;
                    end
                end else begin
                    r_d.freq = target_c;
                end
            end
            default: r_d.freq = r_q.freq;
        endcase

        r_d.lock_cnt = r_q.lock_cnt + 32'h1;
        if (r_q.st != dtm_pkg::DTM_ST_NORMAL) begin
            r_d.lock_cnt = '0;
            r_d.lock_ok = 1'b1;
            r_d.locked = 1'b0;
        end else begin
            if ((phase_err_in[15] ? 16'(-phase_err_in) : phase_err_in)
                >= r_q.lock_thr) begin
                r_d.lock_ok = 1'b0;
            end
            if (r_q.lock_cnt >= LOCK_CYC - 1) begin
                r_d.lock_cnt = '0;
                r_d.locked = r_q.lock_ok;
                r_d.lock_ok = 1'b1;
            end
        end

        // Registered outputs
        r_d.freq_o = r_q.freq;
        r_d.ref_o = r_q.act_ref;
        r_d.run_o = (r_q.st != dtm_pkg::DTM_ST_RESET);
        r_d.trk_o = (r_q.st == dtm_pkg::DTM_ST_NORMAL);
        r_d.ck_en = r_d.run_o ? 6'h3f : 6'h00;
        r_d.fp_en = r_d.run_o ? 5'h1f : 5'h00;
    end

    // ========================================
    // State register
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r_q <= '0;
            r_q.loop_control_reg <= dtm_pkg::DTM_RST_LOOP_CTRL;
            r_q.reference_change_control <= dtm_pkg::DTM_RST_REF_CHANGE;
            r_q.centre_q <= dtm_pkg::DTM_RST_CENTRE_FREQ;
            r_q.lock_thr <= dtm_pkg::DTM_RST_LOCK_THR;
            r_q.st <= dtm_pkg::DTM_ST_FREERUN;
            r_q.lock_ok <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign prdata_out         = r_q.rdata;
    assign pready_out         = r_q.ready;
    assign pslverr_out        = r_q.slverr;
    assign nco_freq_out       = r_q.freq_o;
    assign active_ref_out     = r_q.ref_o;
    assign loop_run_out       = r_q.run_o;
    assign track_ref_out      = r_q.trk_o;
    assign locked_out         = r_q.locked;
    assign out_clk_en_out     = r_q.ck_en;
    assign frame_pulse_en_out = r_q.fp_en;

endmodule

// file: dtm_ref_src.sv
// Reference source model: reference pins, quality flags, phase error
`timescale 1ns/10ps
module dtm_ref_src (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        arst_n_in,
    // Scenario control
    input  wire logic [3:0]  good_mask_in,
    input  wire logic [15:0] phase_in,
    // Toward the loop
    output logic      [3:0]  refs_out,
    output logic      [3:0]  ref_valid_out,
    output logic      [15:0] phase_err_out
);
    logic [3:0] div_q;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
    // Each source toggles at its own rate; a lost one stops
    assign refs_out      = div_q & good_mask_in;
    assign ref_valid_out = good_mask_in;
    // One-count dither stands for reference jitter
    assign phase_err_out = phase_in ^ {15'h0, div_q[0]};
endmodule

// file: dtm_timing_ctrl_assertions.sv
// Port-level property checker for the timing-mode control block
`timescale 1ns/10ps
module dtm_chk #(
    parameter int unsigned NCO_W = 32
) (
    // Clock, reset and APB
    input wire logic             sys_clk_in,
    input wire logic             arst_n_in,
    input wire logic             psel_in,
    input wire logic             penable_in,
    input wire logic             pwrite_in,
    input wire logic [7:0]       paddr_in,
    input wire logic [31:0]      pwdata_in,
    input wire logic [31:0]      prdata_out,
    input wire logic             pready_out,
    input wire logic             pslverr_out,
    // Loop outputs
    input wire logic [NCO_W-1:0] nco_freq_out,
    input wire logic             loop_run_out,
    input wire logic             track_ref_out,
    input wire logic [5:0]       out_clk_en_out,
    input wire logic [4:0]       frame_pulse_en_out
);
    // ========================================
    // Register shadows
    logic        wr_s;
    logic [31:0] ctr_q;
    logic [31:0] dlt_q;
    logic [4:0]  lc_q;
    logic [1:0]  md_q;
    assign wr_s = psel_in && !penable_in && pwrite_in;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctr_q <= dtm_pkg::DTM_RST_CENTRE_FREQ;
            dlt_q <= 32'h0;
            lc_q  <= 5'h0;
            md_q  <= dtm_pkg::DTM_RST_REF_CHANGE[1:0];
        end else if (wr_s) begin
            case (paddr_in)
                dtm_pkg::DTM_OFF_CENTRE_FREQ: ctr_q <= pwdata_in;
                dtm_pkg::DTM_OFF_DELTA_FREQ:  dlt_q <= pwdata_in;
                dtm_pkg::DTM_OFF_LOOP_CTRL:   lc_q  <= pwdata_in[4:0];
                dtm_pkg::DTM_OFF_REF_CHANGE:  md_q  <= pwdata_in[1:0];
                default: ;
            endcase
        end
    end
    // ========================================
    // Properties
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_irm_wr;
        wr_s && paddr_in == dtm_pkg::DTM_OFF_LOOP_CTRL && pwdata_in[0];
    endsequence
    sequence s_fast_steer;
        wr_s && paddr_in == dtm_pkg::DTM_OFF_DELTA_FREQ && md_q == 2'h3
            && lc_q[4:3] == 2'h3 && !lc_q[0];
    endsequence
    a_ready_after_setup:
        assert property (s_setup |=> pready_out)
        else $error("no ready one cycle after setup");
    a_ready_one_cycle:
        assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    a_err_reads_zero:
        assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
        else $error("error response malformed");
    a_irm_stops_run:
        assert property (s_irm_wr |-> ##[1:3] !loop_run_out)
        else $error("loop kept running in internal reset");
    a_irm_outputs_off:
        assert property (!loop_run_out |->
            out_clk_en_out == 6'h0 && frame_pulse_en_out == 5'h0)
        else $error("outputs enabled while loop stopped");
    a_run_outputs_on:
        assert property (loop_run_out |->
            out_clk_en_out == 6'h3f && frame_pulse_en_out == 5'h1f)
        else $error("not all outputs enabled while running");
    a_track_needs_run:
        assert property (track_ref_out |-> loop_run_out)
        else $error("tracking while loop stopped");
    a_freerun_no_track:
        assert property (md_q == 2'h3 [*4] |-> !track_ref_out)
        else $error("tracking in freerun");
    a_steer_immediate:
        assert property (s_fast_steer |->
            ##[1:4] nco_freq_out == NCO_W'(ctr_q + dlt_q))
        else $error("immediate steer offset not applied");
endmodule
bind dtm_timing_ctrl dtm_chk #(.NCO_W(NCO_W)) u_chk (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .nco_freq_out(nco_freq_out), .loop_run_out(loop_run_out),
    .track_ref_out(track_ref_out), .out_clk_en_out(out_clk_en_out),
    .frame_pulse_en_out(frame_pulse_en_out));

// file: dtm_timing_ctrl_tb.sv
// Self-checking bench for the timing-mode control block
`timescale 1ns/10ps
module dtm_timing_ctrl_tb;
    localparam logic [7:0] LC = dtm_pkg::DTM_OFF_LOOP_CTRL;
    localparam logic [7:0] RC = dtm_pkg::DTM_OFF_REF_CHANGE;
    localparam logic [7:0] ST = dtm_pkg::DTM_OFF_STATUS;
    localparam logic [7:0] FN = dtm_pkg::DTM_OFF_FREQ_NOW;
    localparam logic [31:0] CF = dtm_pkg::DTM_RST_CENTRE_FREQ;
    logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        run, track, locked;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, nco, v, f0, f1;
    logic [3:0]  refs, valid, good_mask;
    logic [15:0] phase_err, phase_set;
    logic [1:0]  act_ref;
    logic [5:0]  clk_en;
    logic [4:0]  fp_en;
    int          mismatches, check_count;
    logic [11:0] at_cfg [9] = '{12'h002, 12'h002, 12'h002, 12'h002, 12'h002,
                               12'h132, 12'h132, 12'h132, 12'h132};
    logic [3:0]  at_m [9] = '{4'h4, 4'h8, 4'h3, 4'h0, 4'h2,
                             4'hf, 4'h7, 4'h6, 4'hf};
    logic [5:0]  at_e [9] = '{6'h22, 6'h32, 6'h02, 6'h03, 6'h12,
                             6'h32, 6'h02, 6'h03, 6'h32};

    dtm_timing_ctrl #(.LOCK_CYC(16), .SAVE_CYC(16), .NCO_W(32)) DUT (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .timing_ref_inputs_in(refs),
        .ref_valid_in(valid), .phase_err_in(phase_err),
        .nco_freq_out(nco), .active_ref_out(act_ref), .loop_run_out(run),
        .track_ref_out(track), .locked_out(locked),
        .out_clk_en_out(clk_en), .frame_pulse_en_out(fp_en));
    dtm_ref_src u_src (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .good_mask_in(good_mask),
        .phase_in(phase_set), .refs_out(refs), .ref_valid_out(valid),
        .phase_err_out(phase_err));

    // ========================================
    // Tasks
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wait_rd(input string nm, input logic [7:0] a,
                           input logic [31:0] m, e);
        logic [31:0] r;
        int n;
        n = 0;
        do begin
            xfer(a, 1'b0, 32'h0, r);
            n++;
        end while ((r & m) !== e && n < 80);
        chk(nm, e, r & m);
    endtask

    // ========================================
    // Clock, watchdog and tests
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        test_done();
    end
    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        good_mask = 4'h0;
        phase_set = 16'h0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        xfer(LC, 1'b0, 32'h0, v);
        chk("loop ctrl", dtm_pkg::DTM_RST_LOOP_CTRL, v);
        xfer(RC, 1'b0, 32'h0, v);
        chk("ref change", dtm_pkg::DTM_RST_REF_CHANGE, v);
        xfer(dtm_pkg::DTM_OFF_LOCK_THR, 1'b0, 32'h0, v);
        chk("lock thr", {16'h0, dtm_pkg::DTM_RST_LOCK_THR}, v);
        xfer(8'h1c, 1'b0, 32'h0, v);
        chk("unmapped", 32'h1, {31'h0, err});
        wait_rd("start freq", FN, '1, CF);
        $display("test reset done");
        xfer(RC, 1'b1, 32'h3, v);
        good_mask <= 4'hf;
        phase_set <= 16'h0100;
        xfer(dtm_pkg::DTM_OFF_DELTA_FREQ, 1'b1, 32'h100, v);
        wait_rd("freerun", ST, 32'h7, 32'h1);
        xfer(FN, 1'b0, 32'h0, v);
        chk("no steer", CF, v);
        xfer(LC, 1'b1, 32'h18, v);
        xfer(dtm_pkg::DTM_OFF_DELTA_FREQ, 1'b1, 32'h200, v);
        xfer(FN, 1'b0, 32'h0, v);
        chk("fast steer", CF + 32'h200, v);
        xfer(LC, 1'b1, 32'h0, v);
        wait_rd("steer off", FN, '1, CF);
        xfer(LC, 1'b1, 32'h08, v);
        xfer(dtm_pkg::DTM_OFF_DELTA_FREQ, 1'b1, 32'h4000, v);
        xfer(FN, 1'b0, 32'h0, v);
        chk("no jump", 32'h1, {31'h0, v !== CF + 32'h4000});
        repeat (64) @(posedge sys_clk);
        xfer(FN, 1'b0, 32'h0, v);
        chk("moving", 32'h1, {31'h0, v > CF});
        $display("test freerun done");
        xfer(LC, 1'b1, 32'h1, v);
        wait_rd("irm state", ST, 32'h7, 32'h0);
        chk("irm outputs", 32'h0, {20'h0, run, fp_en, clk_en});
        wait_rd("irm keeps", RC, '1, 32'h3);
        xfer(dtm_pkg::DTM_OFF_CENTRE_FREQ, 1'b1, CF + 32'h1000, v);
        wait_rd("irm write", dtm_pkg::DTM_OFF_CENTRE_FREQ, '1,
                CF + 32'h1000);
        xfer(LC, 1'b1, 32'h0, v);
        wait_rd("new centre", FN, '1, CF + 32'h1000);
        chk("run outputs", 32'hfff, {20'h0, run, fp_en, clk_en});
        $display("test internal reset done");
        xfer(RC, 1'b1, 32'h20, v);
        wait_rd("forced ref", ST, 32'h37, 32'h22);
        chk("tracking", 32'h1, {31'h0, track});
        phase_set <= 16'h0002;
        wait_rd("lock", ST, 32'h40, 32'h40);
        phase_set <= 16'h0100;
        wait_rd("unlock", ST, 32'h40, 32'h0);
        xfer(FN, 1'b0, 32'h0, f0);
        xfer(RC, 1'b1, 32'h21, v);
        wait_rd("holdover", ST, 32'h7, 32'h3);
        xfer(FN, 1'b0, 32'h0, f1);
        chk("restore older", 32'h1, {31'h0, f1 < f0});
        repeat (40) @(posedge sys_clk);
        xfer(FN, 1'b0, 32'h0, v);
        chk("hold steady", 32'h1, {31'h0, v === f1});
        chk("hold track", 32'h0, {31'h0, track});
        $display("test forced modes done");
        for (int i = 0; i < 9; i++) begin
            good_mask <= at_m[i];
            xfer(RC, 1'b1, {20'h0, at_cfg[i]}, v);
            wait_rd("auto", ST, at_e[i][0] ? 32'h7 : 32'h37,
                    {26'h0, at_e[i]});
        end
        $display("test automatic done");
        test_done();
    end
endmodule
